/* logic/sgf_pkg.sv */
/*
 * Package of the switch global forwarding control block: register word
 * indices, field positions, reset values, reserved group codes and the
 * load meter timing. Assumes a 200 MHz core clock and AHB-Lite access
 * with one aligned 32-bit word per register.
 */
package sgf_pkg;

	// Register indices as printed; byte address is four times the index.
	localparam logic [7:0] SGF_IDX_SWITCH_MODE = 8'h20;
	localparam logic [7:0] SGF_IDX_LED_SEQ = 8'h24;
	localparam logic [7:0] SGF_IDX_TREE_STATE = 8'h30;
	localparam logic [7:0] SGF_IDX_LOOKUP_MISS = 8'h3b;
	localparam logic [7:0] SGF_IDX_RES_GROUP = 8'h50;
	localparam logic [7:0] SGF_IDX_LOAD_METER = 8'h51;
	localparam logic [7:0] SGF_IDX_UCAST_MAP = 8'h54;
	localparam logic [7:0] SGF_IDX_MCAST_MAP = 8'h58;
	localparam logic [7:0] SGF_IDX_STATUS = 8'h5c;

	// Switch mode bit positions.
	localparam int SGF_MODE_CBB = 4;
	localparam int SGF_MODE_FAST = 3;
	localparam int SGF_MODE_RETRY = 2;
	localparam int SGF_MODE_FWD = 1;
	localparam int SGF_MODE_MGD = 0;
	// Lookup miss control bit positions.
	localparam int SGF_MISS_MCAST = 7;
	localparam int SGF_MISS_UCAST = 6;
	localparam int SGF_MISS_IPGRP = 0;
	// Reserved group control: learn bit.
	localparam int SGF_RES_LEARN = 7;

	// Reset values of the stored fields, and the flood port map.
	localparam logic [2:0] SGF_RST_MODE_HI = 3'h1;
	localparam logic [15:0] SGF_RST_LED = 16'h0720;
	localparam logic [7:0] SGF_RST_MISS = 8'h01;
	localparam logic [7:0] SGF_RST_RES = 8'h02;
	localparam logic [3:0] SGF_RST_METER = 4'h3;
	localparam logic [16:0] SGF_RST_MAP = 17'h00000;
	localparam logic [16:0] SGF_FLOOD_MAP = 17'h1ffff;

	// Reserved group address prefix and low byte boundaries.
	localparam logic [39:0] SGF_RES_PREFIX = 40'h0180c20000;
	localparam logic [7:0] SGF_RES_BPDU = 8'h00;
	localparam logic [7:0] SGF_RES_R1_LO = 8'h02;
	localparam logic [7:0] SGF_RES_R1_HI = 8'h0f;
	localparam logic [7:0] SGF_RES_SINGLE = 8'h10;
	localparam logic [7:0] SGF_RES_R3_LO = 8'h11;
	localparam logic [7:0] SGF_RES_R3_HI = 8'h1f;
	localparam logic [7:0] SGF_RES_R4_LO = 8'h20;
	localparam logic [7:0] SGF_RES_R4_HI = 8'h2f;

	// Load meter timing: one slot per code step, capped at eight slots.
	localparam int SGF_CLK_KHZ = 200000;
	localparam int SGF_SLOT_MS = 40;
	localparam int SGF_SLOT_CYCLES = SGF_SLOT_MS * SGF_CLK_KHZ;
	localparam logic [3:0] SGF_METER_MAX_CODE = 4'h7;

	// AHB-Lite encodings.
	localparam logic [1:0] SGF_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] SGF_HTRANS_SEQ = 2'h3;

endpackage

/* logic/sgf_global_ctrl.sv */
/*
 * Global forwarding control register set of the switch: switch mode,
 * lamp sequence, lookup miss policy, reserved group controls, miss port
 * maps, tree port state and the load meter tick, with the per-frame
 * forwarding verdict that these settings steer.
 * Assumes a single AHB-Lite master, whole-word transfers, synchronous
 * inputs on ref_clk, and a forwarding strap that is steady at reset.
 */
// Summary of operation
// RL1 - Bypass bit 1 defers to carrier sense.
// RL2 - Release bit picks link-down packet freeing algorithm.
// RL3 - Retry cap off: unlimited half-duplex retries.
// RL4 - Forwarding happens only while forwarding bit set.
// RL5 - Forwarding bit loads strap level at power-on.
// RL6 - Host loads tables before enabling forwarding.
// RL7 - Managed select loads inverted strap at power-on.
// RL8 - Reserved groups handled per managed or unmanaged.
// RL9 - Lamp mode 10:8 resets 111, rate 20h.
// RL10 - Multicast miss: flood, or follow forward rules.
// RL11 - Unicast miss: flood, or follow forward rules.
// RL12 - IP group scheme bit, resets to one.
// RL13 - Learn bit enables learning reserved group sources.
// RL14 - Drop bit 4 covers groups 20 to 2F.
// RL15 - Drop bit 3 covers groups 11 to 1F.
// RL16 - Drop bit 1 covers 02 to 0F, resets one.
// RL17 - Drop bits 2 and 0 cover 10, 00.
// RL18 - Meter code sets period, 40 ms steps, reset 3.
// RL19 - Unicast miss uses unicast miss port map.
// RL20 - Multicast miss uses multicast miss port map.
// RL21 - Tree states ignored in unmanaged mode.
// RL22 - Meter period saturates at 320 ms.
// RL23 - Strap sampled once after reset release.
module sgf_global_ctrl
	import sgf_pkg::*;
#(
	parameter int SLOT_CYCLES = SGF_SLOT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic forwarding_strap,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic carrier_block_bypass,
	output logic quick_release,
	output logic retry_cap_off,
	output logic forwarding_on,
	output logic managed_select,
	output logic [2:0] lamp_sequence_select,
	output logic [7:0] blink_rate,
	output logic ip_group_scheme_on,
	output logic [2:0] tree_port_state,
	output logic load_meter_tick,
	input wire logic lkp_valid,
	input wire logic [47:0] lkp_dest,
	input wire logic lkp_miss,
	output logic lkp_done,
	output logic lkp_drop,
	output logic [16:0] lkp_port_map,
	output logic lkp_learn,
	output logic lkp_to_mgmt
);

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		logic [4:0] mode; // Switch mode bits 4:0.
		logic [15:0] led; // Lamp control word.
		logic [7:0] miss; // Lookup miss control.
		logic [7:0] resv; // Reserved group control.
		logic [3:0] meter; // Load meter period code.
		logic [16:0] umap; // Unicast miss port map.
		logic [16:0] mmap; // Multicast miss port map.
		logic [2:0] tree; // Tree port state as written.
		logic [2:0] tree_vis; // Tree port state as seen outside.
		logic strap_done; // Strap has been taken.
		logic strap_seen; // Strap level as taken.
		logic wr_pend; // Data phase of a write is due.
		logic [7:0] wr_idx; // Word index of that write.
		logic [31:0] rdata; // Read data for the data phase.
		logic [22:0] cyc; // Cycles within the current slot.
		logic [2:0] slot; // Slots elapsed in the period.
		logic tick; // Period end pulse.
		logic done; // Lookup verdict valid pulse.
		logic drop; // Lookup verdict: drop.
		logic [16:0] pmap; // Lookup verdict: port map.
		logic learn; // Lookup verdict: learn source.
		logic mgmt; // Lookup verdict: copy to management.
	} sgf_state_type;

	sgf_state_type st; // Registered state.
	sgf_state_type next_st; // Next state.

	// Bus and lookup address decode wires.
	logic acc; // Valid address phase this cycle.
	logic mapped; // Address is word-aligned and inside the low window.
	logic [7:0] idx; // Word index of the address phase.
	logic [4:0] hit; // Reserved range hits of the lookup address.
	logic is_mcast; // Lookup address is a group address.

	// One-hot reserved range match; bit n pairs with drop bit n.
	function automatic logic [4:0] sgf_res_match(input logic [47:0] da);
		logic [7:0] lo;
		logic pre;
		lo = da[7:0];
		pre = (da[47:8] == SGF_RES_PREFIX);
		sgf_res_match[0] = pre && (lo == SGF_RES_BPDU);
		sgf_res_match[1] = pre && (lo >= SGF_RES_R1_LO) &&
			(lo <= SGF_RES_R1_HI);
		sgf_res_match[2] = pre && (lo == SGF_RES_SINGLE);
		sgf_res_match[3] = pre && (lo >= SGF_RES_R3_LO) &&
			(lo <= SGF_RES_R3_HI);
		sgf_res_match[4] = pre && (lo >= SGF_RES_R4_LO) &&
			(lo <= SGF_RES_R4_HI);
	endfunction

	// Number of slots, minus one, for a meter code; saturates at seven.
	function automatic logic [2:0] sgf_last_slot(input logic [3:0] code);
		if (code > SGF_METER_MAX_CODE) begin
			sgf_last_slot = SGF_METER_MAX_CODE[2:0];
		end else begin
			sgf_last_slot = code[2:0];
		end
	endfunction

	// Address phase and lookup address decode. Only word-aligned addresses in the low window
	// reach a register; the rest read zero and ignore writes.
	assign acc = hsel && hready &&
		((htrans == SGF_HTRANS_NONSEQ) || (htrans == SGF_HTRANS_SEQ));
	assign idx = haddr[9:2];
	assign mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
	assign hit = sgf_res_match(lkp_dest);
	assign is_mcast = lkp_dest[40];

	// Next-state logic for bus, strap, meter and lookup verdict.
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		next_st.done = 1'b0;

		// Writes land in the data phase, using hwdata of that cycle.
		if (st.wr_pend) begin
			case (st.wr_idx)
				SGF_IDX_SWITCH_MODE: begin
					next_st.mode = hwdata[4:0]; // RL1 RL2 RL3
				end
				SGF_IDX_LED_SEQ: begin
					next_st.led = hwdata[15:0]; // RL9
				end
				SGF_IDX_TREE_STATE: begin
					next_st.tree = hwdata[2:0];
				end
				SGF_IDX_LOOKUP_MISS: begin
					next_st.miss = hwdata[7:0]; // RL10 RL11 RL12
				end
				SGF_IDX_RES_GROUP: begin
					next_st.resv = hwdata[7:0]; // RL13
				end
				SGF_IDX_LOAD_METER: begin
					next_st.meter = hwdata[3:0]; // RL18
				end
				SGF_IDX_UCAST_MAP: begin
					next_st.umap = hwdata[16:0];
				end
				SGF_IDX_MCAST_MAP: begin
					next_st.mmap = hwdata[16:0];
				end
				default: begin
					// Unmapped or read-only word: the write is dropped.
				end
			endcase
		end
		next_st.wr_pend = acc && hwrite && mapped;
		next_st.wr_idx = idx;

		// Read data is fetched at the address phase so it stands from
		// flip-flops for the whole data phase.
		if (acc && !hwrite && mapped) begin
			case (idx)
				SGF_IDX_SWITCH_MODE: begin
					next_st.rdata = {27'h0000000, st.mode};
				end
				SGF_IDX_LED_SEQ: begin
					next_st.rdata = {16'h0000, st.led};
				end
				SGF_IDX_TREE_STATE: begin
					next_st.rdata = {29'h00000000, st.tree};
				end
				SGF_IDX_LOOKUP_MISS: begin
					next_st.rdata = {24'h000000, st.miss};
				end
				SGF_IDX_RES_GROUP: begin
					next_st.rdata = {24'h000000, st.resv};
				end
				SGF_IDX_LOAD_METER: begin
					next_st.rdata = {28'h0000000, st.meter};
				end
				SGF_IDX_UCAST_MAP: begin
					next_st.rdata = {15'h0000, st.umap};
				end
				SGF_IDX_MCAST_MAP: begin
					next_st.rdata = {15'h0000, st.mmap};
				end
				SGF_IDX_STATUS: begin
					// Strap level as taken after reset release, and the live meter position.
					next_st.rdata = {26'h0000000, st.slot,
						st.tick, st.strap_done, st.strap_seen};
				end
				default: begin
					next_st.rdata = 32'h00000000;
				end
			endcase
		end else if (acc) begin
			next_st.rdata = 32'h00000000;
		end

		// The strap is taken on the first edge after reset release and
		// never again; it outranks a write landing on that same edge.
		if (!st.strap_done) begin
			next_st.strap_done = 1'b1; // RL23
			next_st.strap_seen = forwarding_strap; // RL23
			next_st.mode[SGF_MODE_FWD] = forwarding_strap; // RL5
			next_st.mode[SGF_MODE_MGD] = !forwarding_strap; // RL7
		end

		// Load meter: count whole slots, end the period after the last.
		// A code lowered to or below the slots already counted ends the period at the end of the current slot.
		if (st.cyc == 23'(SLOT_CYCLES - 1)) begin
			next_st.cyc = 23'h000000;
			if (st.slot >= sgf_last_slot(st.meter)) begin
				next_st.slot = 3'h0; // RL18 RL22
				next_st.tick = 1'b1; // RL18 RL22
			end else begin
				next_st.slot = st.slot + 3'h1;
			end
		end else begin
			next_st.cyc = st.cyc + 23'h000001;
		end

		// Lookup verdict, one cycle after the request.
		if (lkp_valid) begin
			next_st.done = 1'b1;
			next_st.drop = 1'b0;
			next_st.mgmt = 1'b0;
			next_st.pmap = SGF_FLOOD_MAP;
			// Sources of reserved groups are learned only when allowed.
			next_st.learn = (hit == 5'h00) ||
				st.resv[SGF_RES_LEARN]; // RL13
			if (!st.mode[SGF_MODE_FWD]) begin
				next_st.drop = 1'b1; // RL4
				next_st.pmap = SGF_RST_MAP; // RL4
			end else if (hit != 5'h00) begin
				// Managed mode also hands reserved frames that survive
				// the drop controls to the management port.
				next_st.drop = |(hit & st.resv[4:0]); // RL14 RL15 RL16 RL17
				next_st.mgmt = st.mode[SGF_MODE_MGD] &&
					!(|(hit & st.resv[4:0])); // RL8
			end else if (lkp_miss && is_mcast) begin
				if (st.miss[SGF_MISS_MCAST]) begin
					next_st.pmap = st.mmap; // RL10 RL20
				end
			end else if (lkp_miss) begin
				if (st.miss[SGF_MISS_UCAST]) begin
					next_st.pmap = st.umap; // RL11 RL19
				end
			end
		end

		// The visible tree state is registered so that the port comes
		// straight from a flip-flop; it follows the bits landing now.
		next_st.tree_vis = next_st.mode[SGF_MODE_MGD] ?
			next_st.tree : 3'h0; // RL21
	end

	// State register; every field starts from a constant.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.mode <= {2'h0, SGF_RST_MODE_HI[0], 2'h0}; // RL3
			st.led <= SGF_RST_LED; // RL9
			st.miss <= SGF_RST_MISS; // RL11 RL12
			st.resv <= SGF_RST_RES; // RL16
			st.meter <= SGF_RST_METER; // RL18
			st.umap <= SGF_RST_MAP;
			st.mmap <= SGF_RST_MAP;
		end else begin
			st <= next_st;
		end
	end

	// Zero-wait slave: always ready, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;

	// Control outputs straight from the stored fields.
	assign carrier_block_bypass = st.mode[SGF_MODE_CBB]; // RL1
	assign quick_release = st.mode[SGF_MODE_FAST]; // RL2
	assign retry_cap_off = st.mode[SGF_MODE_RETRY]; // RL3
	assign forwarding_on = st.mode[SGF_MODE_FWD]; // RL4
	assign managed_select = st.mode[SGF_MODE_MGD]; // RL7
	assign lamp_sequence_select = st.led[10:8]; // RL9
	assign blink_rate = st.led[7:0]; // RL9
	assign ip_group_scheme_on = st.miss[SGF_MISS_IPGRP]; // RL12
	// Unmanaged mode hides the stored state so that writes stay inert.
	assign tree_port_state = st.tree_vis; // RL21
	assign load_meter_tick = st.tick;
	assign lkp_done = st.done;
	assign lkp_drop = st.drop;
	assign lkp_port_map = st.pmap;
	assign lkp_learn = st.learn;
	assign lkp_to_mgmt = st.mgmt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Forwarding off gives a drop verdict on the next cycle.
	chk_fwd_gate: assert property ( // RL4
		lkp_valid && !forwarding_on |=> lkp_done && lkp_drop &&
			(lkp_port_map == SGF_RST_MAP))
		else $error("lookup passed while forwarding off");

	// The strap sets both mode bits on the first edge.
	chk_strap_load: assert property ( // RL5 RL7
		!st.strap_done |=> (forwarding_on == $past(forwarding_strap)) &&
			(managed_select == !$past(forwarding_strap)))
		else $error("strap not loaded into mode bits");

	// After the strap is taken only a mode write moves the bits.
	chk_strap_once: assert property ( // RL23
		st.strap_done && !(st.wr_pend &&
			(st.wr_idx == SGF_IDX_SWITCH_MODE)) |=>
			$stable(forwarding_on) && $stable(managed_select))
		else $error("strap bits moved without a write");

	// Tree state port is zero whenever unmanaged.
	chk_tree_hide: assert property ( // RL21
		!managed_select |-> tree_port_state == 3'h0)
		else $error("tree state visible in unmanaged mode");

	// Unicast miss with the policy set uses the unicast map.
	chk_ucast_map: assert property ( // RL11 RL19
		lkp_valid && forwarding_on && lkp_miss && !is_mcast &&
			(hit == 5'h00) && st.miss[SGF_MISS_UCAST] |=>
			lkp_port_map == $past(st.umap))
		else $error("unicast miss map not applied");

	// Multicast miss with the policy clear floods.
	chk_mcast_flood: assert property ( // RL10
		lkp_valid && forwarding_on && lkp_miss && is_mcast &&
			(hit == 5'h00) && !st.miss[SGF_MISS_MCAST] |=>
			(lkp_port_map == SGF_FLOOD_MAP) && !lkp_drop)
		else $error("multicast miss not flooded");

	// A reserved group with its drop bit set is dropped.
	chk_res_drop: assert property ( // RL14 RL15 RL16 RL17
		lkp_valid && forwarding_on && (|(hit & st.resv[4:0])) |=>
			lkp_drop && !lkp_to_mgmt)
		else $error("reserved group not dropped");

	// A period never ends before its slot count is reached.
	chk_meter_slots: assert property ( // RL18 RL22
		load_meter_tick |-> $past(st.slot) >= sgf_last_slot($past(st.meter))
			&& (st.slot == 3'h0) && (st.cyc == 23'h000000))
		else $error("load meter period ended early");

	// A read in one phase shows the stored word in the next.
	chk_led_read: assert property ( // RL9
		acc && !hwrite && mapped && (idx == SGF_IDX_LED_SEQ) |=>
			hrdata == {16'h0000, $past(st.led)})
		else $error("lamp word read back wrong");

endmodule

/* sim/sgf_global_ctrl_tb_top.sv */
/*
 * Self-checking bench of the switch global forwarding control block.
 * Assumes the design package, a 200 MHz ref_clk and a lone AHB-Lite
 * master (this bench) whose hready is the slave's own hreadyout.
 */
module sgf_global_ctrl_tb_top
	import sgf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short meter slot so that whole periods fit in a quick run.
	localparam int SLOT = 20;
	localparam int LIMIT = 20000;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic forwarding_strap = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, cbb, qrel, rcap, fwd, mgd, tick;
	logic [31:0] hrdata;
	logic [2:0] lamp, tree;
	logic [7:0] blink;
	logic ipg, lkp_done, lkp_drop, lkp_learn, lkp_to_mgmt;
	logic lkp_valid = 1'b0;
	logic [47:0] lkp_dest = 48'h0;
	logic lkp_miss = 1'b0;
	logic [16:0] lkp_port_map;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) \
	begin n_mismatch++; \
	$display("mismatch %s expected %0h seen %0h", what, exp, got); end end

	// Hready is fed back from the only slave on the bus.
	sgf_global_ctrl #(.SLOT_CYCLES(SLOT)) dut_u (.ref_clk(ref_clk),
		.rst_n(rst_n), .forwarding_strap(forwarding_strap), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .carrier_block_bypass(cbb),
		.quick_release(qrel), .retry_cap_off(rcap), .forwarding_on(fwd),
		.managed_select(mgd), .lamp_sequence_select(lamp),
		.blink_rate(blink), .ip_group_scheme_on(ipg),
		.tree_port_state(tree), .load_meter_tick(tick),
		.lkp_valid(lkp_valid), .lkp_dest(lkp_dest), .lkp_miss(lkp_miss),
		.lkp_done(lkp_done), .lkp_drop(lkp_drop),
		.lkp_port_map(lkp_port_map), .lkp_learn(lkp_learn),
		.lkp_to_mgmt(lkp_to_mgmt));

	// Free-running core clock, 5 ns period.
	always #2.5 ref_clk = ~ref_clk;

	// A hang is cut short here and still reaches the closing report.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			results();
		end
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Waits for an edge at which hready is sampled high.
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1 && n < 100) begin
			n++;
			@(posedge ref_clk);
		end
	endtask

	// One single-word transfer; read data are taken at the data phase end.
	task automatic bus(input logic [7:0] idx, input logic wr,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= SGF_HTRANS_NONSEQ;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask

	// Writes one word, then reads it back and compares.
	task automatic wr_rd(input logic [7:0] idx, input logic [31:0] d,
		input logic [31:0] exp);
		logic [31:0] r;
		bus(idx, 1'b1, d, r);
		bus(idx, 1'b0, 32'h0, r);
		`CHK("readback", exp, r)
	endtask

	// Holds reset for eight cycles with the given strap level.
	task automatic do_reset(input logic strap);
		rst_n <= 1'b0;
		forwarding_strap <= strap;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask

	// Presents one lookup and returns on the edge that closes the verdict
	// cycle, where the verdict just given still stands.
	task automatic lookup(input logic [47:0] d, input logic m);
		lkp_valid <= 1'b1;
		lkp_dest <= d;
		lkp_miss <= m;
		@(posedge ref_clk);
		lkp_valid <= 1'b0;
		@(posedge ref_clk);
		`CHK("lkp_done", 1'b1, lkp_done)
	endtask

	// Reset values of the mode, lamp, miss, reserved group, meter and status words, unmapped place included.
	task automatic test_reset_values();
		logic [31:0] r;
		bus(SGF_IDX_SWITCH_MODE, 1'b0, 32'h0, r);
		`CHK("mode", 32'h06, r)
		bus(SGF_IDX_LED_SEQ, 1'b0, 32'h0, r);
		`CHK("led", 32'h0720, r)
		bus(SGF_IDX_LOOKUP_MISS, 1'b0, 32'h0, r);
		`CHK("miss", 32'h01, r)
		bus(SGF_IDX_RES_GROUP, 1'b0, 32'h0, r);
		`CHK("resgrp", 32'h02, r)
		bus(SGF_IDX_LOAD_METER, 1'b0, 32'h0, r);
		`CHK("meter", 32'h3, r)
		`CHK("ipg", 1'b1, ipg)
		`CHK("lamp", 11'h720, {lamp, blink})
		bus(SGF_IDX_STATUS, 1'b0, 32'h0, r);
		`CHK("status strap", 2'b11, r[1:0])
		wr_rd(8'h21, 32'hffffffff, 32'h0);
		$display("test reset_values done");
	endtask

	// Mode bits follow writes; a later strap change moves nothing.
	task automatic test_mode();
		forwarding_strap <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("fwd strap", 2'b10, {fwd, mgd})
		wr_rd(SGF_IDX_SWITCH_MODE, 32'hff, 32'h1f);
		`CHK("mode on", 5'h1f, {cbb, qrel, rcap, fwd, mgd})
		wr_rd(SGF_IDX_SWITCH_MODE, 32'h0, 32'h0);
		`CHK("mode off", 5'h0, {cbb, qrel, rcap, fwd, mgd})
		lookup(48'h020000000001, 1'b0);
		`CHK("fwd off", 18'h20000, {lkp_drop, lkp_port_map})
		wr_rd(SGF_IDX_SWITCH_MODE, 32'h06, 32'h06);
		$display("test mode done");
	endtask

	// Stored widths of the plain read-write words.
	task automatic test_rw();
		wr_rd(SGF_IDX_LED_SEQ, 32'hffffffff, 32'hffff);
		`CHK("lamp all", 11'h7ff, {lamp, blink})
		wr_rd(SGF_IDX_LED_SEQ, 32'h0520, 32'h0520);
		`CHK("lamp set", 11'h520, {lamp, blink})
		wr_rd(SGF_IDX_LOOKUP_MISS, 32'hfe, 32'hfe);
		`CHK("ipg off", 1'b0, ipg)
		wr_rd(SGF_IDX_LOAD_METER, 32'hff, 32'h0f);
		wr_rd(SGF_IDX_UCAST_MAP, 32'hffffffff, 32'h1ffff);
		$display("test rw done");
	endtask

	// Each reserved group range against its drop bit, plus neighbours.
	task automatic test_reserved();
		logic [7:0] lo [10] = '{8'h00, 8'h02, 8'h0f, 8'h10, 8'h11,
			8'h1f, 8'h20, 8'h2f, 8'h01, 8'h30};
		int bn [10] = '{0, 1, 1, 2, 3, 3, 4, 4, -1, -1};
		logic [7:0] cfg [2] = '{8'h1f, 8'h80};
		logic hit, dr;
		for (int c = 0; c < 2; c++) begin
			wr_rd(SGF_IDX_RES_GROUP, {24'h0, cfg[c]}, {24'h0, cfg[c]});
			for (int i = 0; i < 10; i++) begin
				hit = (bn[i] >= 0);
				dr = hit && cfg[c][bn[i]];
				lookup({SGF_RES_PREFIX, lo[i]}, 1'b0);
				`CHK("res drop", dr, lkp_drop)
				`CHK("res learn", !hit || cfg[c][7], lkp_learn)
				`CHK("res map", SGF_FLOOD_MAP, lkp_port_map)
				`CHK("res mgmt", 1'b0, lkp_to_mgmt)
			end
		end
		$display("test reserved done");
	endtask

	// Lookup misses flood or take the miss maps by policy.
	task automatic test_miss();
		logic [31:0] r;
		bus(SGF_IDX_UCAST_MAP, 1'b1, 32'h00015, r);
		bus(SGF_IDX_MCAST_MAP, 1'b1, 32'h0a0a0, r);
		for (int p = 0; p < 2; p++) begin
			bus(SGF_IDX_LOOKUP_MISS, 1'b1, {24'h0, p[0], p[0], 6'h01}, r);
			lookup(48'h020000000001, 1'b1);
			`CHK("ucast", p ? 17'h00015 : 17'h1ffff, lkp_port_map)
			lookup(48'h030000000001, 1'b1);
			`CHK("mcast", p ? 17'h0a0a0 : 17'h1ffff, lkp_port_map)
			`CHK("miss drop", 1'b0, lkp_drop)
		end
		$display("test miss done");
	endtask

	// Tick spacing per code, saturating above seven.
	task automatic test_meter();
		logic [3:0] code [3] = '{4'h0, 4'h2, 4'h9};
		int exp, n;
		logic [31:0] r;
		for (int c = 0; c < 3; c++) begin
			bus(SGF_IDX_LOAD_METER, 1'b1, {28'h0, code[c]}, r);
			exp = ((code[c] > 7) ? 8 : code[c] + 1) * SLOT;
			for (int k = 0; k < 2; k++) begin
				n = 0;
				do begin
					@(posedge ref_clk);
					n++;
				end while (tick !== 1'b1 && n < 400);
			end
			`CHK("meter period", exp, n)
		end
		$display("test meter done");
	endtask

	// Managed start: tree state honoured, reserved copies to management.
	task automatic test_managed();
		logic [31:0] r;
		wr_rd(SGF_IDX_TREE_STATE, 32'h5, 32'h5);
		`CHK("tree unmanaged", 3'h0, tree)
		do_reset(1'b0);
		`CHK("strap low", 2'b01, {fwd, mgd})
		lookup({SGF_RES_PREFIX, 8'h0e}, 1'b0);
		`CHK("held off", 1'b1, lkp_drop)
		// The read back lets the write land before the port is judged.
		wr_rd(SGF_IDX_TREE_STATE, 32'h5, 32'h5);
		`CHK("tree managed", 3'h5, tree)
		bus(SGF_IDX_RES_GROUP, 1'b1, 32'h0, r);
		bus(SGF_IDX_SWITCH_MODE, 1'b1, 32'h03, r);
		lookup({SGF_RES_PREFIX, 8'h0e}, 1'b0);
		`CHK("mgmt copy", 2'b01, {lkp_drop, lkp_to_mgmt})
		$display("test managed done");
	endtask

	// Main sequence.
	initial begin
		do_reset(1'b1);
		test_reset_values();
		test_mode();
		test_rw();
		test_reserved();
		test_miss();
		test_meter();
		test_managed();
		results();
	end
endmodule
